// ### common/ltdo_regs.vh
/*
  register map, field positions, reset values and timing constants for the
  limit test / digital output block. assumes a 32-bit apb slave, byte addresses.
*/
`ifndef LTDO_REGS_VH
`define LTDO_REGS_VH

// ==========================================================
// register offsets (byte addresses)
`define LTDO_OFF_CTRL      12'h000
`define LTDO_OFF_CMD       12'h004
`define LTDO_OFF_UPA       12'h008
`define LTDO_OFF_LOA       12'h00c
`define LTDO_OFF_UPB       12'h010
`define LTDO_OFF_LOB       12'h014
`define LTDO_OFF_PULSE_MS  12'h018
`define LTDO_OFF_STATUS    12'h01c
`define LTDO_OFF_EVENT     12'h020
`define LTDO_OFF_SIGN      12'h024

// ==========================================================
// control register fields
`define LTDO_CTRL_EN_A     0
`define LTDO_CTRL_EN_B     1
`define LTDO_CTRL_ACLR_A   2
`define LTDO_CTRL_ACLR_B   3
`define LTDO_CTRL_SENSE_LO 4
`define LTDO_CTRL_OUT_EN   5
`define LTDO_CTRL_PULSE    6
`define LTDO_CTRL_LATCH    7
`define LTDO_CTRL_RESET    8'h0c

// ==========================================================
// command register fields (write-one pulses)
`define LTDO_CMD_CLR_A     0
`define LTDO_CMD_CLR_B     1
`define LTDO_CMD_PANEL_OFF 2

// ==========================================================
// bound reset values, 33-bit two's complement magnitude field
`define LTDO_UPA_RESET     33'h0_0000_0001
`define LTDO_LOA_RESET     33'h1_ffff_ffff
`define LTDO_UPB_RESET     33'h0_0000_0002
`define LTDO_LOB_RESET     33'h1_ffff_fffe
`define LTDO_BOUND_MAX     33'h0_ffff_ffff

// ==========================================================
// pulse timing: duration held in milliseconds
`define LTDO_PULSE_MS_RESET 27'd2
`define LTDO_PULSE_MS_MIN   27'd1
`define LTDO_PULSE_MS_MAX   27'd99999999
`define LTDO_CLK_HZ         100000000
`define LTDO_MS_CYCLES      (`LTDO_CLK_HZ / 1000)

`endif

// ### verilog/ltdo_compare.v
/*
  one limit pair comparator: signed reading against upper and lower bounds.
  assumes 33-bit two's complement operands, purely combinational.
*/
`timescale 1ns/100ps

module ltdo_compare #(
  parameter W = 33                  // operand width
) (
  input  wire [W-1:0] reading,       // signed reading
  input  wire [W-1:0] upper,         // signed upper bound
  input  wire [W-1:0] lower,         // signed lower bound
  input  wire         enable,        // pair test enabled
  output wire         hit_hi,        // reading at or above upper
  output wire         hit_lo         // reading at or below lower
);

  // ==========================================================
  // compare; equal to a bound counts as failing, disabled never fails
  assign hit_hi = enable & ($signed(reading) >= $signed(upper));
  assign hit_lo = enable & ($signed(reading) <= $signed(lower));

endmodule // ltdo_compare

// ### verilog/ltdo_pulse.v
/*
  pulse timer for the digital outputs: a millisecond tick divider and a
  down counter in milliseconds. assumes one clock, start/stop from same domain.
*/
`timescale 1ns/100ps
`include "ltdo_regs.vh"

module ltdo_pulse #(
  parameter MS_CYCLES = `LTDO_MS_CYCLES   // clock cycles per millisecond
) (
  input  wire        pclk,          // clock
  input  wire        presetn,       // async reset, active low
  input  wire        start,         // begin a pulse (failing reading)
  input  wire        stop,          // abort (in-limit reading)
  input  wire [26:0] dur_ms,        // duration in milliseconds
  output reg         active_r       // pulse running
);

  // ==========================================================
  // millisecond tick divider, restarted at each pulse start
  reg  [31:0] div_r;                // cycle count inside a millisecond
  reg  [26:0] ms_r;                 // milliseconds left
  wire        tick;                 // one-cycle millisecond enable

  assign tick = (div_r == MS_CYCLES - 1);

  // ----------------------------------------------------------
  // load count at start, count down on ticks; start wins over stop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r    <= 32'h0000_0000;
      ms_r     <= 27'h000_0000;
      active_r <= 1'b0;
    end else if (start) begin
      div_r    <= 32'h0000_0000;
      ms_r     <= dur_ms;
      active_r <= 1'b1;
    end else if (stop) begin
      active_r <= 1'b0;
    end else if (active_r) begin
      div_r <= tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
      if (tick) begin
        // last millisecond ends the pulse
        if (ms_r <= 27'h000_0001) begin
          active_r <= 1'b0;
        end
        ms_r <= ms_r - 27'h000_0001;
      end
    end
  end

endmodule // ltdo_pulse

// ### verilog/ltdo_top.v
/*
  limit test and digital output block: apb register file, two limit pairs,
  sticky fail flags, five output lines with polarity, pulse and master latch.
  assumes readings arrive as one-cycle strobes on pclk and that idle and
  trigger-source passes are one-cycle strobes from the sequencing logic.
*/
// What this block does
// - pair a bounds, signed, defaults 1 and -1
// - pair b bounds, same range, defaults 2, -2
// - separate pair enables; disabled pair never fails
// - fail when reading reaches or passes bound
// - fail flag one bit; hi/lo in events
// - clear command resets pair fail flag
// - autoclear on idle entry, default enabled
// - without autoclear flag holds until clear
// - output polarity select, active high default
// - global output enable, off after reset
// - pulse duration 0.001..99999.999 s, default 0.002
// - master latch enable, default off
// - pair b indication when only b enabled
// - panel limit disable turns off both pairs
// - channel slot 1/2, two-digit channel number
// - every completed reading goes to enabled tests
// - pulse per failing reading, cut by pass
// - master line on any fail, latched or not
// - lines: lo a, hi a, lo b, hi b, master
`timescale 1ns/100ps
`include "ltdo_regs.vh"

module ltdo_top #(
  parameter MS_CYCLES = `LTDO_MS_CYCLES   // cycles per millisecond
) (
  input  wire        pclk,           // apb clock, 100 MHz
  input  wire        presetn,        // async reset, active low
  input  wire        psel,           // apb select
  input  wire        penable,        // apb access phase
  input  wire        pwrite,         // apb direction
  input  wire [11:0] paddr,          // apb byte address
  input  wire [31:0] pwdata,         // apb write data
  output reg  [31:0] prdata,         // apb read data
  output wire        pready,         // apb ready
  output wire        pslverr,        // apb error
  input  wire        rd_valid,       // completed measurement strobe
  input  wire [32:0] rd_value,       // signed reading
  input  wire [7:0]  rd_chan,        // reading channel: slot*100+ch coded
  input  wire        idle_enter,     // operation enters idle, one cycle
  input  wire        ctl_src_pass,   // trigger passes control source
  input  wire        panel_lim_off,  // panel limit disable, one cycle
  output reg  [4:0]  dout_r,         // digital output lines 1..5
  output reg         ind_hi_r,       // high annunciator
  output reg         ind_lo_r,       // low annunciator
  output reg         ind_in_r,       // in-limit indication
  output reg  [1:0]  ind_pair_r      // pair shown: 1 or 2, 0 none
);

  // ==========================================================
  // registers
  reg  [7:0]  ctrl_r;                // control bits
  reg  [32:0] upa_r;                 // pair a upper bound
  reg  [32:0] loa_r;                 // pair a lower bound
  reg  [32:0] upb_r;                 // pair b upper bound
  reg  [32:0] lob_r;                 // pair b lower bound
  reg  [26:0] pulse_ms_r;            // pulse duration, ms
  reg  [1:0]  fail_r;                // sticky fail flags a, b
  reg  [3:0]  event_r;               // sticky lo a, hi a, lo b, hi b
  reg  [3:0]  hit_r;                 // last reading per bound
  reg         master_r;              // master line state
  reg  [7:0]  last_chan_r;           // channel of last reading

  wire        wr_en;                 // write taken this cycle
  wire        rd_en;                 // read taken this cycle
  wire        hia;                   // pair a high hit
  wire        loa;                   // pair a low hit
  wire        hib;                   // pair b high hit
  wire        lob;                   // pair b low hit
  wire [3:0]  hit;                   // lo a, hi a, lo b, hi b
  wire        any_fail;              // any bound failing now
  wire        pulse_on;              // pulse timer running
  wire        clr_a;                 // clear pair a
  wire        clr_b;                 // clear pair b

  // ==========================================================
  // apb slave: zero wait states, error on unmapped addresses
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);

  // mapped address decode, used by the error response only
  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a[1:0] == 2'b00) && (a <= `LTDO_OFF_SIGN);
    end
  endfunction

  // negate-or-zero-extend a 32-bit magnitude by its sign bit into 33 bits
  function [32:0] to_bound;
    input [31:0] mag;
    input        neg;
    begin
      to_bound = neg ? (33'h0_0000_0000 - {1'b0, mag}) : {1'b0, mag};
    end
  endfunction

  // clamp pulse duration into the programmable range
  function [26:0] clamp_ms;
    input [31:0] v;
    begin
      if (v < {5'h00, `LTDO_PULSE_MS_MIN}) begin
        clamp_ms = `LTDO_PULSE_MS_MIN;
      end else if (v > {5'h00, `LTDO_PULSE_MS_MAX}) begin
        clamp_ms = `LTDO_PULSE_MS_MAX;
      end else begin
        clamp_ms = v[26:0];
      end
    end
  endfunction

  // ----------------------------------------------------------
  // bounds are written as magnitude plus a sticky sign register;
  // software writes the sign word first, then the magnitude
  reg  [3:0] sign_r;                 // sign for upa, loa, upb, lob

  // ==========================================================
  // configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `LTDO_CTRL_RESET;
      upa_r      <= `LTDO_UPA_RESET;
      loa_r      <= `LTDO_LOA_RESET;
      upb_r      <= `LTDO_UPB_RESET;
      lob_r      <= `LTDO_LOB_RESET;
      pulse_ms_r <= `LTDO_PULSE_MS_RESET;
      sign_r     <= 4'h0;
    end else begin
      if (panel_lim_off) begin
        // panel disable drops both pairs at once
        ctrl_r[`LTDO_CTRL_EN_A] <= 1'b0;
        ctrl_r[`LTDO_CTRL_EN_B] <= 1'b0;
      end else if (wr_en && paddr == `LTDO_OFF_CTRL) begin
        ctrl_r <= pwdata[7:0];
      end
      if (wr_en) begin
        case (paddr)
          `LTDO_OFF_SIGN:     sign_r     <= pwdata[3:0];
          `LTDO_OFF_UPA:      upa_r      <= to_bound(pwdata, sign_r[0]);
          `LTDO_OFF_LOA:      loa_r      <= to_bound(pwdata, sign_r[1]);
          `LTDO_OFF_UPB:      upb_r      <= to_bound(pwdata, sign_r[2]);
          `LTDO_OFF_LOB:      lob_r      <= to_bound(pwdata, sign_r[3]);
          `LTDO_OFF_PULSE_MS: pulse_ms_r <= clamp_ms(pwdata);
          default:            sign_r     <= sign_r;
        endcase
      end
    end
  end

  // clear commands are write-one pulses, not stored
  assign clr_a = wr_en && (paddr == `LTDO_OFF_CMD) && pwdata[`LTDO_CMD_CLR_A];
  assign clr_b = wr_en && (paddr == `LTDO_OFF_CMD) && pwdata[`LTDO_CMD_CLR_B];

  // ==========================================================
  // comparators, one per pair
  ltdo_compare #(.W(33)) u_cmp_a (
    .reading (rd_value),
    .upper   (upa_r),
    .lower   (loa_r),
    .enable  (ctrl_r[`LTDO_CTRL_EN_A]),
    .hit_hi  (hia),
    .hit_lo  (loa)
  );

  ltdo_compare #(.W(33)) u_cmp_b (
    .reading (rd_value),
    .upper   (upb_r),
    .lower   (lob_r),
    .enable  (ctrl_r[`LTDO_CTRL_EN_B]),
    .hit_hi  (hib),
    .hit_lo  (lob)
  );

  assign hit      = {hib, lob, hia, loa};   // bit order = line 4..1
  assign any_fail = |hit;

  // ==========================================================
  // fail flags and event bits; a reading that fails in the clear
  // cycle wins, so no failure is ever dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_r      <= 2'b00;
      event_r     <= 4'h0;
      hit_r       <= 4'h0;
      last_chan_r <= 8'h00;
    end else begin
      if (rd_valid) begin
        hit_r       <= hit;
        last_chan_r <= rd_chan;
      end
      // pair a flag: set on fail, clear by command or idle autoclear
      if (rd_valid && (hia || loa)) begin
        fail_r[0] <= 1'b1;
      end else if (clr_a || (idle_enter && ctrl_r[`LTDO_CTRL_ACLR_A])) begin
        fail_r[0] <= 1'b0;
      end
      // pair b flag
      if (rd_valid && (hib || lob)) begin
        fail_r[1] <= 1'b1;
      end else if (clr_b || (idle_enter && ctrl_r[`LTDO_CTRL_ACLR_B])) begin
        fail_r[1] <= 1'b0;
      end
      // hi/lo detail kept apart from the one-bit flags; read clears
      if (rd_valid) begin
        event_r <= (rd_en && paddr == `LTDO_OFF_EVENT) ? hit : (event_r | hit);
      end else if (rd_en && paddr == `LTDO_OFF_EVENT) begin
        event_r <= 4'h0;
      end
    end
  end

  // ==========================================================
  // pulse timer
  ltdo_pulse #(.MS_CYCLES(MS_CYCLES)) u_pulse (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (rd_valid & any_fail & ctrl_r[`LTDO_CTRL_PULSE]),
    .stop     (rd_valid & ~any_fail),
    .dur_ms   (pulse_ms_r),
    .active_r (pulse_on)
  );

  // ==========================================================
  // master line: latched holds until control-source pass
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_r <= 1'b0;
    end else if (rd_valid && any_fail) begin
      master_r <= 1'b1;
    end else if (ctrl_r[`LTDO_CTRL_LATCH]) begin
      if (ctl_src_pass) begin
        master_r <= 1'b0;
      end
    end else if (rd_valid) begin
      master_r <= 1'b0;                      // in all bounds
    end
  end

  // ==========================================================
  // output lines: level or pulse, polarity, global enable
  reg [4:0] act;                             // active-high line state
  always @* begin
    act = {master_r, hit_r};
    if (ctrl_r[`LTDO_CTRL_PULSE] && !pulse_on) begin
      act[3:0] = 4'h0;                       // pulsed lines idle
    end
    if (!ctrl_r[`LTDO_CTRL_OUT_EN]) begin
      act = 5'h00;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_r <= 5'h00;                       // inactive, active-high default
    end else begin
      dout_r <= ctrl_r[`LTDO_CTRL_SENSE_LO] ? ~act : act;
    end
  end

  // ==========================================================
  // front indicators: pair a when enabled, else pair b when enabled, else none
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_hi_r   <= 1'b0;
      ind_lo_r   <= 1'b0;
      ind_in_r   <= 1'b0;
      ind_pair_r <= 2'd0;
    end else if (ctrl_r[`LTDO_CTRL_EN_A]) begin
      ind_hi_r   <= hit_r[1];
      ind_lo_r   <= hit_r[0];
      ind_in_r   <= ~|hit_r[1:0];
      ind_pair_r <= 2'd1;
    end else if (ctrl_r[`LTDO_CTRL_EN_B]) begin
      ind_hi_r   <= hit_r[3];
      ind_lo_r   <= hit_r[2];
      ind_in_r   <= ~|hit_r[3:2];            // inside pair b message
      ind_pair_r <= 2'd2;
    end else begin
      ind_hi_r   <= 1'b0;
      ind_lo_r   <= 1'b0;
      ind_in_r   <= 1'b0;
      ind_pair_r <= 2'd0;
    end
  end

  // ==========================================================
  // read mux; bounds read back as 32-bit magnitude, sign in sign register
  always @* begin
    case (paddr)
      `LTDO_OFF_CTRL:     prdata = {24'h00_0000, ctrl_r};
      `LTDO_OFF_UPA:      prdata = upa_r[32] ? (32'h0 - upa_r[31:0]) : upa_r[31:0];
      `LTDO_OFF_LOA:      prdata = loa_r[32] ? (32'h0 - loa_r[31:0]) : loa_r[31:0];
      `LTDO_OFF_UPB:      prdata = upb_r[32] ? (32'h0 - upb_r[31:0]) : upb_r[31:0];
      `LTDO_OFF_LOB:      prdata = lob_r[32] ? (32'h0 - lob_r[31:0]) : lob_r[31:0];
      `LTDO_OFF_PULSE_MS: prdata = {5'h00, pulse_ms_r};
      `LTDO_OFF_STATUS:   prdata = {16'h0000, last_chan_r, 4'h0, pulse_on,
                                    master_r, fail_r};
      `LTDO_OFF_EVENT:    prdata = {28'h000_0000, event_r};
      `LTDO_OFF_SIGN:     prdata = {28'h0, lob_r[32], upb_r[32], loa_r[32], upa_r[32]};
      default:            prdata = 32'h0000_0000;
    endcase
  end

endmodule // ltdo_top

// ### tb/ltdo_top_asserts.sv
/* checker for ltdo_top, bound to its ports.
   assumes apb writes land at the access edge with zero wait states. */
`timescale 1ns/100ps
module ltdo_top_asserts #(
  parameter MS_CYCLES = 4              // cycles per millisecond
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        rd_valid,
  input wire [7:0]  rd_chan,
  input wire        ctl_src_pass,
  input wire        panel_lim_off,
  input wire [4:0]  dout_r,
  input wire        ind_hi_r,
  input wire        ind_lo_r,
  input wire        ind_in_r,
  input wire [1:0]  ind_pair_r
);
  // ====
  // shadow of config written over apb
  reg  [7:0]  ctrl_q;                  // control copy
  reg  [26:0] pms_q;                   // pulse ms copy, clamped
  reg  [2:0]  age_q;                   // edges since control write or panel disable
  reg  [7:0]  chan_q;                  // last channel
  reg  [31:0] pcnt_q;                  // run length of active lines
  wire        wr  = psel && penable && pwrite && pready;
  wire [3:0]  act = dout_r[3:0] ^ {4{ctrl_q[4]}};
  // age saturates; lines lag a config write by one edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h0c;
      pms_q  <= 27'h2;
      age_q  <= 3'h0;
      chan_q <= 8'h00;
      pcnt_q <= 32'h0;
    end else begin
      age_q  <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
      if (wr && paddr == 12'h000) begin
        ctrl_q <= pwdata[7:0];
        age_q  <= 3'h0;
      end else if (panel_lim_off) begin
        ctrl_q <= {ctrl_q[7:2], 2'b00};
        age_q  <= 3'h0;
      end
      if (wr && paddr == 12'h018)
        pms_q <= (pwdata == 32'h0) ? 27'h1 : (pwdata > 32'd99999999) ? 27'd99999999 : pwdata[26:0];
      if (rd_valid)
        chan_q <= rd_chan;
      pcnt_q <= (rd_valid || act == 4'h0) ? 32'h0 : pcnt_q + 32'h1;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_quiet: assert property ($rose(presetn) |-> dout_r == 5'h00)
    else $error("lines active after reset");
  chk_off_inactive: assert property (age_q >= 3'h2 && !ctrl_q[5] |-> dout_r == {5{ctrl_q[4]}})
    else $error("lines not idle while disabled");
  chk_master_any: assert property (age_q >= 3'h2 && ctrl_q[7:5] == 3'b001
    |-> (dout_r[4] ^ ctrl_q[4]) == (|act)) else $error("master not the or of the lines");
  chk_master_hold: assert property (age_q >= 3'h2 && ctrl_q[5] && ctrl_q[7]
    && (dout_r[4] ^ ctrl_q[4]) && !ctl_src_pass && !$past(ctl_src_pass)
    |=> dout_r[4] == $past(dout_r[4]))
    else $error("latched master released early");
  chk_pulse_len: assert property (age_q >= 3'h2 && ctrl_q[6:5] == 2'b11
    |-> pcnt_q <= pms_q * MS_CYCLES + 4) else $error("pulse too long");
  chk_pair_off: assert property (rd_valid && age_q >= 3'h2 && ctrl_q[1:0] == 2'b00
    |-> ##2 (age_q < 3'h4 || act == 4'h0)) else $error("disabled pair drove a line");
  chk_ind_excl: assert property (ind_in_r |-> !ind_hi_r && !ind_lo_r && ind_pair_r != 2'h3)
    else $error("in-limit shown with a crossing");
  chk_stat_chan: assert property (psel && penable && !pwrite && paddr == 12'h01c
    |-> prdata[15:8] == chan_q) else $error("status channel stale");
  cover property (ctrl_q[7] && ctl_src_pass);
  cover property (rd_valid && ctrl_q[6:5] == 2'b11);
  cover property (panel_lim_off);
endmodule // ltdo_top_asserts

bind ltdo_top ltdo_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

// ### tb/ltdo_handler.sv
/* component handler model: bins each part from the output lines.
   assumes lines settle two edges after the reading strobe. */
`timescale 1ns/100ps
module ltdo_handler (
  input  wire       pclk,              // clock
  input  wire       rd_valid,          // reading strobe
  input  wire       sense_low,         // lines active low
  input  wire [4:0] lines,             // digital output lines
  output reg        bin_v,             // decision strobe
  output reg  [1:0] bin,               // 1 in, 2 first pair, 3 second pair
  output reg  [4:0] seen               // lines sampled for the part
);
  reg  [1:0] dly = 2'b00;              // reading age
  wire [4:0] act = lines ^ {5{sense_low}};
  // second pair outranks first, as a sorter would bin it
  always @(posedge pclk) begin
    dly   <= {dly[0], rd_valid};
    bin_v <= dly[1];
    seen  <= lines;
    bin   <= (act[2] | act[3]) ? 2'h3 : (act[0] | act[1]) ? 2'h2 : 2'h1;
  end
endmodule // ltdo_handler

// ### tb/limit_test_digital_outputs_tb_top.sv
/* bench for ltdo_top: apb host tasks, a reading driver noting expected
   lines, the handler model and the checker.
   assumes a shortened millisecond of 4 cycles. */
`timescale 1ns/100ps
`include "ltdo_regs.vh"
module limit_test_digital_outputs_tb_top;
  // ====
  // stimulus, outputs and bench state
  reg         pclk, presetn, psel, penable, pwrite, rd_valid;
  reg         idle_enter, ctl_src_pass, panel_lim_off, rerr, mlat;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rv;              // rv: last read data
  reg  [32:0] rd_value;
  reg  [7:0]  rd_chan, ctrl;           // ctrl: control copy
  reg  [3:0]  sg;                      // bound signs
  reg  [6:0]  note;                    // bin and lines
  reg  [6:0]  expq [$];                // notes per reading
  wire [31:0] prdata;
  wire        pready, pslverr, ind_hi_r, ind_lo_r, ind_in_r, bin_v;
  wire [4:0]  dout_r, seen;
  wire [1:0]  ind_pair_r, bin;
  longint     bnd [4];                 // upper a, lower a, upper b, lower b
  longint     vals [8];
  integer     errors, total_checks, seed, i;
  ltdo_top #(.MS_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid), .rd_value(rd_value),
    .rd_chan(rd_chan), .idle_enter(idle_enter), .ctl_src_pass(ctl_src_pass),
    .panel_lim_off(panel_lim_off), .dout_r(dout_r), .ind_hi_r(ind_hi_r),
    .ind_lo_r(ind_lo_r), .ind_in_r(ind_in_r), .ind_pair_r(ind_pair_r));
  ltdo_handler hdl (.pclk(pclk), .rd_valid(rd_valid), .sense_low(ctrl[4]),
    .lines(dout_r), .bin_v(bin_v), .bin(bin), .seen(seen));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ====
  // tasks
  task automatic chk(input string nm, input [32:0] e, input [32:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready
  task apb(input bit w, input [11:0] a, input [31:0] d);
    integer n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      finish_test;
    end
    rv = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // sign first, then magnitude
  task bound(input int k, input longint v);
    bnd[k] = v;
    sg[k] = v < 0;
    apb(1, `LTDO_OFF_SIGN, {28'h0, sg});
    apb(1, 12'(`LTDO_OFF_UPA + 4 * k), 32'(v < 0 ? -v : v));
  endtask
  task setc(input [7:0] c);
    ctrl = c;
    apb(1, `LTDO_OFF_CTRL, {24'h0, c});
  endtask
  task strobe(input [2:0] m);
    @(posedge pclk);
    {idle_enter, ctl_src_pass, panel_lim_off} <= m;
    @(posedge pclk);
    {idle_enter, ctl_src_pass, panel_lim_off} <= 3'h0;
  endtask
  function [6:0] exp_lines(input longint v);
    reg [4:0] h;
    h[0] = ctrl[0] && v <= bnd[1];
    h[1] = ctrl[0] && v >= bnd[0];
    h[2] = ctrl[1] && v <= bnd[3];
    h[3] = ctrl[1] && v >= bnd[2];
    mlat = ctrl[7] && (mlat || |h[3:0]);
    h[4] = ctrl[7] ? mlat : |h[3:0];
    h = ctrl[5] ? h : 5'h00;
    exp_lines = {(h[2] | h[3]) ? 2'h3 : (h[0] | h[1]) ? 2'h2 : 2'h1, h ^ {5{ctrl[4]}}};
  endfunction
  // back-to-back readings allowed
  task rdg(input longint v);
    @(posedge pclk);
    rd_valid <= 1'b1;
    rd_value <= 33'(v);
    rd_chan  <= 8'($random(seed));
    expq.push_back(exp_lines(v));
  endtask
  task drain;
    integer n;
    @(posedge pclk);
    rd_valid <= 1'b0;
    for (n = 0; n < 20 && expq.size() != 0; n++)
      @(posedge pclk);
    if (expq.size() != 0) begin
      errors++;
      $display("ERROR queue expected 0 seen %0d", expq.size());
      finish_test;
    end
  endtask
  // ====
  // monitor: oldest note against each handler decision
  always @(posedge pclk) begin
    if (bin_v === 1'b1) begin
      note = expq.pop_front();
      chk("lines", note[4:0], seen);
      chk("bin", note[6:5], bin);
    end
  end
  initial begin
    #900000;
    errors++;
    $display("ERROR run expected end seen timeout");
    finish_test;
  end
  // ====
  // main sequence
  initial begin
    {psel, penable, pwrite, rd_valid, idle_enter, ctl_src_pass, panel_lim_off} = 7'h0;
    {paddr, pwdata, rd_value, rd_chan} = 85'h0;
    {presetn, mlat, ctrl, sg} = {2'b00, 8'h0c, 4'ha};
    {errors, total_checks, seed} = {32'd0, 32'd0, 32'd37};
    bnd = '{1, -1, 2, -2};
    vals = '{100, 99, -100, -99, 0, 64'd4294967295, -64'd4294967295, 64'd4294967294};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("dout reset", 5'h00, dout_r);
    apb(0, `LTDO_OFF_CTRL, 0);
    chk("ctrl reset", 32'hc, rv);
    for (i = 0; i < 4; i++) begin
      apb(0, 12'(`LTDO_OFF_UPA + 4 * i), 0);
      chk("bound reset", 33'(i / 2 + 1), rv);
    end
    apb(0, `LTDO_OFF_SIGN, 0);
    chk("sign reset", 32'ha, rv);
    apb(0, `LTDO_OFF_PULSE_MS, 0);
    chk("pulse reset", 32'h2, rv);
    apb(0, 12'h028, 0);
    chk("unmapped err", 1, rerr);
    chk("unmapped data", 0, rv);
    setc(8'h01);
    rdg(5);
    drain;
    apb(0, `LTDO_OFF_STATUS, 0);
    chk("flags oe off", 2'h1, rv[1:0]);
    bound(0, 100);
    bound(1, -100);
    bound(2, 64'd4294967295);
    bound(3, -64'd4294967295);
    setc(8'h23);
    for (i = 0; i < 8; i++)
      rdg(vals[i]);
    for (i = 0; i < 8; i++)
      rdg($random(seed) % 300);
    rdg(0);
    drain;
    apb(0, `LTDO_OFF_STATUS, 0);
    chk("sticky flags", 2'h3, rv[1:0]);
    apb(1, `LTDO_OFF_CMD, 32'h3);
    apb(0, `LTDO_OFF_STATUS, 0);
    chk("cleared flags", 2'h0, rv[1:0]);
    setc(8'h2f);
    rdg(500);
    drain;
    strobe(3'b100);
    apb(0, `LTDO_OFF_STATUS, 0);
    chk("idle clear", 2'h0, rv[1:0]);
    setc(8'h33);
    rdg(-150);
    rdg(50);
    rdg(150);
    drain;
    setc(8'ha3);
    strobe(3'b010);
    mlat = 1'b0;
    rdg(200);
    rdg(0);
    rdg(0);
    drain;
    strobe(3'b010);
    mlat = 1'b0;
    rdg(0);
    drain;
    apb(1, `LTDO_OFF_PULSE_MS, 0);
    apb(0, `LTDO_OFF_PULSE_MS, 0);
    chk("pulse min", 32'h1, rv);
    apb(1, `LTDO_OFF_PULSE_MS, 32'd100000000);
    apb(0, `LTDO_OFF_PULSE_MS, 0);
    chk("pulse max", 32'd99999999, rv);
    apb(1, `LTDO_OFF_PULSE_MS, 32'h2);
    setc(8'h63);
    rdg(200);
    drain;
    repeat (20) @(posedge pclk);
    chk("pulse end", 4'h0, dout_r[3:0]);
    chk("master level", 1'b1, dout_r[4]);
    rdg(200);
    drain;
    rdg(0);
    drain;
    setc(8'h22);
    rdg(0);
    drain;
    chk("in pair b", 3'h6, {ind_in_r, ind_pair_r});
    rdg(64'd4294967295);
    drain;
    chk("hi pair b", 3'h6, {ind_hi_r, ind_pair_r});
    setc(8'h23);
    strobe(3'b001);
    ctrl[1:0] = 2'b00;
    apb(0, `LTDO_OFF_CTRL, 0);
    chk("panel off", 32'h20, rv);
    rdg(64'd4294967295);
    drain;
    finish_test;
  end
endmodule // limit_test_digital_outputs_tb_top
